/* hw/port_bc_mux_pkg.sv */
// Purpose: constants for the port B / port C alternate function mux
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes: offsets are byte addresses
package port_bc_mux_pkg;
   localparam logic [7:0] PORT_B_SEL_OFS = 8'h00;
   localparam logic [7:0] PORT_C_SEL_OFS = 8'h04;
   localparam logic [7:0] MODE_OFS = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
   localparam logic [7:0] PIN_STATE_OFS = 8'h14;
   // mode register bits
   localparam int MODE_TIMER_ZERO_COUNTER = 0;
   localparam int MODE_TIMER_ONE_COUNTER = 1;
   localparam int MODE_TIMER_TWO_COUNTER = 2;
   localparam int MODE_IRQ_ZERO_TRIGGER_TYPE = 3;
   localparam int MODE_IRQ_ONE_TRIGGER_TYPE = 4;
   // status bits
   localparam int ST_IRQ4 = 0;
   localparam int ST_IRQ5 = 1;
   localparam int ST_IRQ6 = 2;
   localparam int ST_IRQ0 = 3;
   localparam int ST_IRQ1 = 4;
   localparam int ST_W = 5;
   localparam logic [7:0] SEL_B_RESET = 8'h00;
   localparam logic [5:0] SEL_C_RESET = 6'h00;
   localparam logic [4:0] MODE_RESET = 5'h00;
   localparam logic [4:0] MASK_RESET = 5'h00;
   localparam logic [7:0] PIN_RESET = 8'hFF;
endpackage : port_bc_mux_pkg

/* hw/port_bc_alt_function_mux.sv */
// Purpose: port B (8 pins) and port C (bits 0..5) alternate function mux
// Assumes: pins synchronous to sys_clk; AHB-Lite register slave
// Notes: one wait-free slave, always OKAY
//
// Behaviour
// - select bit 0 connects pin to its bidirectional port bit
// - PB0 ignored while timer two is in timer mode
// - PB1 selected feeds timer two external trigger, active high
// - PB2 selected feeds second UART receive in all modes
// - PB3 selected driven by second UART transmit/shift clock
// - PB4 selected is irq four, rising edge
// - PB5 selected is irq five, falling edge
// - PB6 selected is irq six, rising edge
// - PB7 selected pulses high one cycle per timer two overflow
// - PC0 selected feeds first UART receive in all modes
// - PC1 selected driven by first UART transmit/shift clock
// - PC2 selected is irq zero low; type bit edge or level
// - PC3 selected is irq one low; type bit edge or level
// - PC4 selected feeds timer zero count input, counter mode only
// - PC5 selected feeds timer one count input, counter mode only
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module port_bc_alt_function_mux (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // general purpose port side
   input wire logic [7:0] portBOut,
   input wire logic [7:0] portBOutEn,
   output logic [7:0] portBIn,
   input wire logic [5:0] portCOut,
   input wire logic [5:0] portCOutEn,
   output logic [5:0] portCIn,
   // pins (output enable low while driving)
   input wire logic [7:0] pinBIn,
   output logic [7:0] pinBOut,
   output logic [7:0] pinBOe_n,
   input wire logic [5:0] pinCIn,
   output logic [5:0] pinCOut,
   output logic [5:0] pinCOe_n,
   // core side
   input wire logic secondUartTransmit,
   input wire logic firstUartTransmit,
   input wire logic timerTwoOverflow,
   output logic timerTwoCountInput,
   output logic timerTwoExternalTrigger,
   output logic secondUartReceive,
   output logic firstUartReceive,
   output logic timerZeroCountInput,
   output logic timerOneCountInput,
   output logic irqFourRising,
   output logic irqFiveFalling,
   output logic irqSixRising,
   output logic extIrqZeroLow_n,
   output logic extIrqOneLow_n,
   output logic irq
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] portBFunctionSelect_q;
   logic [5:0] portCFunctionSelect_q;
   logic [4:0] mode_q;
   logic [4:0] irqStat_q;
   logic [4:0] irqMask_q;
   logic [7:0] prevB_q;
   logic [5:0] prevC_q;
   logic [7:0] addr_q;
   logic wrPend_q;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire addrPhase = hsel && hready && htrans[1];
   wire wrB = wrPend_q && addr_q == port_bc_mux_pkg::PORT_B_SEL_OFS;
   wire wrC = wrPend_q && addr_q == port_bc_mux_pkg::PORT_C_SEL_OFS;
   wire wrMode = wrPend_q && addr_q == port_bc_mux_pkg::MODE_OFS;
   wire wrStat = wrPend_q && addr_q == port_bc_mux_pkg::IRQ_STAT_OFS;
   wire wrMask = wrPend_q && addr_q == port_bc_mux_pkg::IRQ_MASK_OFS;
   wire [7:0] rdAddr = haddr[7:0];
   logic [31:0] rdData;
   always_comb begin
      case (rdAddr)
         port_bc_mux_pkg::PORT_B_SEL_OFS: rdData = {24'h000000, portBFunctionSelect_q};
         port_bc_mux_pkg::PORT_C_SEL_OFS: rdData = {26'h0000000, portCFunctionSelect_q};
         port_bc_mux_pkg::MODE_OFS: rdData = {27'h0000000, mode_q};
         port_bc_mux_pkg::IRQ_STAT_OFS: rdData = {27'h0000000, irqStat_q};
         port_bc_mux_pkg::IRQ_MASK_OFS: rdData = {27'h0000000, irqMask_q};
         port_bc_mux_pkg::PIN_STATE_OFS: rdData = {18'h00000, pinCIn, pinBIn};
         default: rdData = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= 8'h00;
         wrPend_q <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         wrPend_q <= addrPhase && hwrite;
         if (addrPhase) begin
            addr_q <= haddr[7:0];
         end
         if (addrPhase && !hwrite) begin
            hrdata <= rdData;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portBFunctionSelect_q <= port_bc_mux_pkg::SEL_B_RESET;
         portCFunctionSelect_q <= port_bc_mux_pkg::SEL_C_RESET;
         mode_q <= port_bc_mux_pkg::MODE_RESET;
         irqMask_q <= port_bc_mux_pkg::MASK_RESET;
      end else begin
         if (wrB) portBFunctionSelect_q <= hwdata[7:0];
         if (wrC) portCFunctionSelect_q <= hwdata[5:0];
         if (wrMode) mode_q <= hwdata[4:0];
         if (wrMask) irqMask_q <= hwdata[4:0];
      end
   end

   // ----------------------------------------
   // pin history for edge detection
   // ----------------------------------------
   // reset high: a high pin at release counts as no edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prevB_q <= port_bc_mux_pkg::PIN_RESET;
         prevC_q <= port_bc_mux_pkg::PIN_RESET[5:0];
      end else begin
         prevB_q <= pinBIn;
         prevC_q <= pinCIn;
      end
   end

   wire [7:0] selB = portBFunctionSelect_q;
   wire [5:0] selC = portCFunctionSelect_q;
   wire rise4 = selB[4] && pinBIn[4] && !prevB_q[4];
   wire fall5 = selB[5] && !pinBIn[5] && prevB_q[5];
   wire rise6 = selB[6] && pinBIn[6] && !prevB_q[6];
   wire fall0 = selC[2] && !pinCIn[2] && prevC_q[2];
   wire fall1 = selC[3] && !pinCIn[3] && prevC_q[3];
   wire low0 = selC[2] && !pinCIn[2];
   wire low1 = selC[3] && !pinCIn[3];
   wire irq0Evt = mode_q[port_bc_mux_pkg::MODE_IRQ_ZERO_TRIGGER_TYPE] ? fall0 : low0;
   wire irq1Evt = mode_q[port_bc_mux_pkg::MODE_IRQ_ONE_TRIGGER_TYPE] ? fall1 : low1;
   wire [4:0] events = {irq1Evt, irq0Evt, rise6, fall5, rise4};
   wire [4:0] statClr = wrStat ? hwdata[4:0] : 5'h00;
   // irq follows the mask written this cycle, so it never lags the mask register
   wire [4:0] maskNext = wrMask ? hwdata[4:0] : irqMask_q;
   wire [4:0] statNext = (irqStat_q & ~statClr) | events;

   // ----------------------------------------
   // sticky status, set wins over clear
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_q <= 5'h00;
         irq <= 1'b0;
      end else begin
         irqStat_q <= statNext;
         irq <= |(statNext & maskNext);
      end
   end

   // ----------------------------------------
   // pin output muxing
   // ----------------------------------------
   logic [7:0] nxtBOut;
   logic [7:0] nxtBOe_n;
   logic [5:0] nxtCOut;
   logic [5:0] nxtCOe_n;
   always_comb begin
      nxtBOut = portBOut;
      nxtBOe_n = ~portBOutEn;
      nxtCOut = portCOut;
      nxtCOe_n = ~portCOutEn;
      if (selB[3]) begin
         nxtBOut[3] = secondUartTransmit;
         nxtBOe_n[3] = 1'b0;
      end
      if (selB[7]) begin
         nxtBOut[7] = timerTwoOverflow;
         nxtBOe_n[7] = 1'b0;
      end
      if (selC[1]) begin
         nxtCOut[1] = firstUartTransmit;
         nxtCOe_n[1] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinBOut <= 8'h00;
         pinBOe_n <= 8'hFF;
         pinCOut <= 6'h00;
         pinCOe_n <= 6'h3F;
      end else begin
         pinBOut <= nxtBOut;
         pinBOe_n <= nxtBOe_n;
         pinCOut <= nxtCOut;
         pinCOe_n <= nxtCOe_n;
      end
   end

   // ----------------------------------------
   // core side inputs
   // ----------------------------------------
   // port inputs always see the pin so software can read it back
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portBIn <= 8'h00;
         portCIn <= 6'h00;
         timerTwoCountInput <= 1'b0;
         timerTwoExternalTrigger <= 1'b0;
         secondUartReceive <= 1'b1;
         firstUartReceive <= 1'b1;
         timerZeroCountInput <= 1'b0;
         timerOneCountInput <= 1'b0;
         irqFourRising <= 1'b0;
         irqFiveFalling <= 1'b0;
         irqSixRising <= 1'b0;
         extIrqZeroLow_n <= 1'b1;
         extIrqOneLow_n <= 1'b1;
      end else begin
         portBIn <= pinBIn;
         portCIn <= pinCIn;
         timerTwoCountInput <= selB[0] && mode_q[port_bc_mux_pkg::MODE_TIMER_TWO_COUNTER]
            && pinBIn[0];
         timerTwoExternalTrigger <= selB[1] && pinBIn[1];
         secondUartReceive <= selB[2] ? pinBIn[2] : 1'b1;
         firstUartReceive <= selC[0] ? pinCIn[0] : 1'b1;
         timerZeroCountInput <= selC[4] && mode_q[port_bc_mux_pkg::MODE_TIMER_ZERO_COUNTER]
            && pinCIn[4];
         timerOneCountInput <= selC[5] && mode_q[port_bc_mux_pkg::MODE_TIMER_ONE_COUNTER]
            && pinCIn[5];
         irqFourRising <= rise4;
         irqFiveFalling <= fall5;
         irqSixRising <= rise6;
         extIrqZeroLow_n <= !irq0Evt;
         extIrqOneLow_n <= !irq1Evt;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_gpio_b;
      @(posedge sys_clk) disable iff (!rst_n)
      !selB[2] |=> pinBOut[2] == $past(portBOut[2]) && pinBOe_n[2] == !$past(portBOutEn[2]);
   endproperty
   a_gpio_b: assert property (p_gpio_b) else $error("gpio passthrough wrong");

   property p_two_timer_mode;
      @(posedge sys_clk) disable iff (!rst_n)
      !mode_q[port_bc_mux_pkg::MODE_TIMER_TWO_COUNTER] |=> !timerTwoCountInput;
   endproperty
   a_two_timer_mode: assert property (p_two_timer_mode) else $error("pin used in timer mode");

   property p_two_ovf;
      @(posedge sys_clk) disable iff (!rst_n)
      selB[7] && timerTwoOverflow ##1 !timerTwoOverflow |-> pinBOut[7] ##1 !pinBOut[7];
   endproperty
   a_two_ovf: assert property (p_two_ovf) else $error("overflow pulse not one cycle");

   property p_irq4;
      @(posedge sys_clk) disable iff (!rst_n)
      selB[4] && pinBIn[4] && !$past(pinBIn[4]) |=> irqFourRising && irqStat_q[0];
   endproperty
   a_irq4: assert property (p_irq4) else $error("rising edge missed");

   property p_irq5;
      @(posedge sys_clk) disable iff (!rst_n)
      irqFiveFalling |-> $past(!pinBIn[5] && selB[5]);
   endproperty
   a_irq5: assert property (p_irq5) else $error("falling edge spurious");

   property p_irq0_level;
      @(posedge sys_clk) disable iff (!rst_n)
      selC[2] && !mode_q[port_bc_mux_pkg::MODE_IRQ_ZERO_TRIGGER_TYPE] && !pinCIn[2]
         |=> !extIrqZeroLow_n;
   endproperty
   a_irq0_level: assert property (p_irq0_level) else $error("level irq zero missed");

   property p_first_uart_tx;
      @(posedge sys_clk) disable iff (!rst_n)
      selC[1] |=> !pinCOe_n[1] && pinCOut[1] == $past(firstUartTransmit);
   endproperty
   a_first_uart_tx: assert property (p_first_uart_tx) else $error("uart transmit not driven");

   property p_irq6;
      @(posedge sys_clk) disable iff (!rst_n)
      selB[6] && pinBIn[6] && !$past(pinBIn[6])
         |=> irqSixRising && irqStat_q[port_bc_mux_pkg::ST_IRQ6];
   endproperty
   a_irq6: assert property (p_irq6) else $error("rising edge six missed");

   property p_rx_b;
      @(posedge sys_clk) disable iff (!rst_n)
      selB[2] |=> secondUartReceive == $past(pinBIn[2]);
   endproperty
   a_rx_b: assert property (p_rx_b) else $error("uart receive wrong");

   property p_zero_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      !(selC[4] && mode_q[port_bc_mux_pkg::MODE_TIMER_ZERO_COUNTER]) |=> !timerZeroCountInput;
   endproperty
   a_zero_gate: assert property (p_zero_gate) else $error("count input not gated");

   property p_irq_out;
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 irq == |(irqStat_q & irqMask_q);
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("interrupt output wrong");
endmodule : port_bc_alt_function_mux
`default_nettype wire

/* testbench/pin_board_model.sv */
// Purpose: board side of the port B and port C pins
// Assumes: weak pull-up on every pin
// Notes: a pin nobody drives reads high
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
   // from the mux
   input wire logic [13:0] pinOut,
   input wire logic [13:0] pinOe_n,
   // board drivers
   input wire logic [13:0] boardEn,
   input wire logic [13:0] boardLvl,
   // resolved levels
   output logic [13:0] pinIn
);
   // mux drive wins, then the board, else the pull-up
   assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & boardEn & boardLvl) | (pinOe_n & ~boardEn);
endmodule : pin_board_model
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the port B/C alternate function mux
// Assumes: zero wait state slave, registered pin paths
// Notes: pins resolved by the board model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk, rst_n, hsel, hwrite, hresp, hreadyout, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] portBOut, portBOutEn, portBIn, pinBOut, pinBOe_n;
   logic [5:0] portCOut, portCOutEn, portCIn, pinCOut, pinCOe_n;
   wire logic [7:0] pinBIn;
   wire logic [5:0] pinCIn;
   logic secondUartTransmit, firstUartTransmit, timerTwoOverflow;
   logic timerTwoCountInput, timerTwoExternalTrigger, secondUartReceive, firstUartReceive;
   logic timerZeroCountInput, timerOneCountInput, irqFourRising, irqFiveFalling, irqSixRising;
   logic extIrqZeroLow_n, extIrqOneLow_n;
   logic [13:0] boardEn, boardLvl;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   wire logic [5:0] coreIn = {timerOneCountInput, timerZeroCountInput, firstUartReceive,
      secondUartReceive, timerTwoExternalTrigger, timerTwoCountInput};
   wire logic [2:0] edgeOut = {irqSixRising, irqFiveFalling, irqFourRising};
   wire logic [1:0] extOut = {extIrqOneLow_n, extIrqZeroLow_n};

   port_bc_alt_function_mux dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .portBOut(portBOut), .portBOutEn(portBOutEn),
      .portBIn(portBIn), .portCOut(portCOut), .portCOutEn(portCOutEn), .portCIn(portCIn),
      .pinBIn(pinBIn), .pinBOut(pinBOut), .pinBOe_n(pinBOe_n), .pinCIn(pinCIn),
      .pinCOut(pinCOut), .pinCOe_n(pinCOe_n), .secondUartTransmit(secondUartTransmit),
      .firstUartTransmit(firstUartTransmit), .timerTwoOverflow(timerTwoOverflow),
      .timerTwoCountInput(timerTwoCountInput),
      .timerTwoExternalTrigger(timerTwoExternalTrigger),
      .secondUartReceive(secondUartReceive), .firstUartReceive(firstUartReceive),
      .timerZeroCountInput(timerZeroCountInput), .timerOneCountInput(timerOneCountInput),
      .irqFourRising(irqFourRising), .irqFiveFalling(irqFiveFalling),
      .irqSixRising(irqSixRising), .extIrqZeroLow_n(extIrqZeroLow_n),
      .extIrqOneLow_n(extIrqOneLow_n), .irq(irq));
   pin_board_model board_u (.pinOut({pinCOut, pinBOut}), .pinOe_n({pinCOe_n, pinBOe_n}),
      .boardEn(boardEn), .boardLvl(boardLvl), .pinIn({pinCIn, pinBIn}));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // a hang ends the run as a failure
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : bus
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic drv(input int i, input logic v);
      @(posedge sys_clk);
      boardEn[i] <= 1'b1;
      boardLvl[i] <= v;
   endtask : drv
   task automatic give_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h40};
      foreach (offs[i]) begin
         bus(1'b0, offs[i], 32'h0);
         chk(rd, 32'h0);
      end
      chk({18'h0, pinCOe_n, pinBOe_n}, 32'h3FFF);
   endtask : t_reset
   task automatic t_gpio();
      @(posedge sys_clk);
      portBOut <= 8'hA5;
      portBOutEn <= 8'h0F;
      portCOut <= 6'h2A;
      portCOutEn <= 6'h30;
      settle(3);
      chk(pinBOe_n, 8'hF0);
      chk(pinCOe_n, 6'h0F);
      chk(portBIn, 8'hF5);
      chk(portCIn, 6'h2F);
      bus(1'b0, port_bc_mux_pkg::PIN_STATE_OFS, 32'h0);
      chk(rd, 32'h2FF5);
      portBOutEn <= 8'h00;
      portCOutEn <= 6'h00;
   endtask : t_gpio
   task automatic route(input logic isC, input int pin, input int idx, input logic [4:0] mode,
         input logic follows);
      logic [7:0] sel;
      sel = isC ? port_bc_mux_pkg::PORT_C_SEL_OFS : port_bc_mux_pkg::PORT_B_SEL_OFS;
      bus(1'b1, sel, 32'h1 << pin);
      bus(1'b1, port_bc_mux_pkg::MODE_OFS, {27'h0, mode});
      drv(isC * 8 + pin, 1'b1);
      settle(3);
      chk(coreIn[idx], follows);
      drv(isC * 8 + pin, 1'b0);
      settle(3);
      chk(coreIn[idx], 1'b0);
      bus(1'b1, sel, 32'h0);
   endtask : route
   task automatic t_out();
      bus(1'b1, port_bc_mux_pkg::PORT_B_SEL_OFS, 32'h88);
      bus(1'b1, port_bc_mux_pkg::PORT_C_SEL_OFS, 32'h02);
      secondUartTransmit <= 1'b1;
      firstUartTransmit <= 1'b1;
      settle(3);
      chk({pinBOut[3], pinCOut[1]}, 2'h3);
      chk({pinBOe_n[7], pinBOe_n[3], pinCOe_n[1]}, 3'h0);
      secondUartTransmit <= 1'b0;
      firstUartTransmit <= 1'b0;
      settle(3);
      chk({pinBOut[3], pinCOut[1]}, 2'h0);
      @(posedge sys_clk);
      timerTwoOverflow <= 1'b1;
      @(posedge sys_clk);
      timerTwoOverflow <= 1'b0;
      #1;
      chk(pinBOut[7], 1'b1);
      settle(1);
      chk(pinBOut[7], 1'b0);
      bus(1'b1, port_bc_mux_pkg::PORT_B_SEL_OFS, 32'h0);
      bus(1'b1, port_bc_mux_pkg::PORT_C_SEL_OFS, 32'h0);
   endtask : t_out
   task automatic t_edge(input int pin, input logic lvl, input int st);
      bus(1'b1, port_bc_mux_pkg::PORT_B_SEL_OFS, 32'h1 << pin);
      drv(pin, lvl);
      settle(3);
      bus(1'b1, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h1F);
      drv(pin, ~lvl);
      settle(1);
      chk(edgeOut[pin - 4], 1'b1);
      settle(1);
      chk(edgeOut[pin - 4], 1'b0);
      bus(1'b0, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'h1 << st);
      chk(irq, 1'b0);
   endtask : t_edge
   task automatic t_mask();
      bus(1'b1, port_bc_mux_pkg::IRQ_MASK_OFS, 32'h04);
      settle(2);
      chk(irq, 1'b1);
      bus(1'b1, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h04);
      settle(2);
      chk(irq, 1'b0);
      bus(1'b1, port_bc_mux_pkg::IRQ_MASK_OFS, 32'h00);
   endtask : t_mask
   task automatic t_ext(input int pin, input int idx, input logic [4:0] mode, input int st);
      bus(1'b1, port_bc_mux_pkg::PORT_C_SEL_OFS, 32'h1 << pin);
      bus(1'b1, port_bc_mux_pkg::MODE_OFS, {27'h0, mode});
      drv(8 + pin, 1'b1);
      settle(3);
      bus(1'b1, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h1F);
      drv(8 + pin, 1'b0);
      settle(1);
      chk(extOut[idx], 1'b0);
      settle(1);
      // level mode stays asserted, edge mode is a single cycle
      chk(extOut[idx], mode != 5'h00);
      bus(1'b0, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h0);
      chk(rd[st], 1'b1);
      drv(8 + pin, 1'b1);
      settle(3);
      chk(extOut[idx], 1'b1);
      bus(1'b1, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h1F);
      bus(1'b0, port_bc_mux_pkg::IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
   endtask : t_ext

   initial begin
      rst_n = 1'b0;
      {hsel, hwrite, htrans, hsize, haddr, hwdata, portBOut, portBOutEn, portCOut, portCOutEn,
         secondUartTransmit, firstUartTransmit, timerTwoOverflow, boardEn, boardLvl} = '0;
      hsize = 3'h2;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_gpio();
      route(1'b0, 0, 0, 5'h00, 1'b0);
      route(1'b0, 0, 0, 5'h04, 1'b1);
      route(1'b0, 1, 1, 5'h00, 1'b1);
      route(1'b0, 2, 2, 5'h00, 1'b1);
      route(1'b1, 0, 3, 5'h00, 1'b1);
      route(1'b1, 4, 4, 5'h00, 1'b0);
      route(1'b1, 4, 4, 5'h01, 1'b1);
      route(1'b1, 5, 5, 5'h02, 1'b1);
      t_out();
      t_edge(4, 1'b0, 0);
      t_edge(5, 1'b1, 1);
      t_edge(6, 1'b0, 2);
      t_mask();
      t_ext(2, 0, 5'h00, 3);
      t_ext(2, 0, 5'h08, 3);
      t_ext(3, 1, 5'h00, 4);
      t_ext(3, 1, 5'h10, 4);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
